// ---- core/daisy_diag_pkg.sv ----
/*
  Constants, field layouts and carrier types for the daisy-chain port
  diagnostic block. Assumes one 40 MHz core clock and an AXI4-Lite
  register bus with 32-bit data and 16-bit byte addresses.
*/
package daisy_diag_pkg;

  localparam int ADDR_W = 16;
  localparam int NPORT  = 2;
  localparam int PORT_HI = 0;
  localparam int PORT_LO = 1;
  localparam logic [1:0] CMD_DIR = 2'b01;  // Per port: dir value for commands

  // Register indices; byte address is four times the index
  localparam logic [13:0] IDX_HI_BIT   = 14'h0783;
  localparam logic [13:0] IDX_HI_RC    = 14'h0784;
  localparam logic [13:0] IDX_HI_RR    = 14'h0785;
  localparam logic [13:0] IDX_LO_BIT   = 14'h0786;
  localparam logic [13:0] IDX_LO_RC    = 14'h0787;
  localparam logic [13:0] IDX_LO_RR    = 14'h0788;
  localparam logic [13:0] IDX_SER_DISC = 14'h0789;
  localparam logic [13:0] IDX_HI_DISC  = 14'h078a;
  localparam logic [13:0] IDX_SER_VHI  = 14'h078c;
  localparam logic [13:0] IDX_SER_VLO  = 14'h078d;
  localparam logic [13:0] IDX_HI_VHI   = 14'h078e;
  localparam logic [13:0] IDX_HI_VLO   = 14'h078f;
  localparam logic [13:0] IDX_IRQ_STAT = 14'h07f0;
  localparam logic [13:0] IDX_IRQ_MASK = 14'h07f1;
  localparam logic [13:0] IDX_CTRL     = 14'h07f2;

  // Control register: bit 0 direction select, 1 high tx en, 2 low tx en
  localparam int CTRL_DIR  = 0;
  localparam int CTRL_HITX = 1;
  localparam int CTRL_LOTX = 2;
  localparam logic [2:0] CTRL_RST = 3'h6;
  localparam int IRQ_W = 7;
  localparam logic [7:0] DIAG_RST = 8'h00;
  localparam logic [7:0] CNT_MAX  = 8'hff;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Per-port receive events from the link decoder, pulses unless noted
  typedef struct packed {
    logic byte_stb;       // One received byte
    logic byte_first;     // Qualifies byte_stb: initialization byte
    logic byte_sof;       // Qualifies byte_stb: start marker bit set
    logic byte_bad;       // Qualifies byte_stb: byte decode error
    logic frame_is_resp;  // Level over the frame: response, not command
    logic frame_end;      // Frame complete
    logic crc_bad;        // Qualifies frame_end: checksum failed
    logic crc_last_bad;   // Qualifies frame_end: byte error on crc byte
    logic tag_in;         // Qualifies frame_end: frame came tagged
    logic abnormal;       // Unclassified abnormality
    logic preamble_miss;
    logic sync_no_data;
    logic weak_bit;
    logic hold_abort;     // Held response dropped by a new command
    logic hold_bcast;     // Qualifies hold_abort: broadcast/stack read
  } port_evt_t;

  typedef struct packed {
    logic discard;
    logic valid;
  } serial_evt_t;

  typedef enum logic [1:0] {
    W_IDLE = 2'b00,
    W_ADDR = 2'b01,
    W_DATA = 2'b10,
    W_RESP = 2'b11
  } wr_state_t;

endpackage

// ---- core/daisy_chain_comm_diagnostics.sv ----
/*
  Diagnostic status for the two daisy-chain ports: error flags per
  port, discard and valid-frame counters, interrupt and AXI4-Lite slave.
  Assumes the link decoders deliver qualified one-cycle event pulses
  synchronous to aclk, and that the forward path honours fwd_tag.
*/
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module daisy_chain_comm_diagnostics (
  // Clock and reset
  input  wire logic                       aclk,
  input  wire logic                       aresetn,
  // AXI4-Lite write address and data
  input  wire logic [daisy_diag_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // AXI4-Lite write response
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // AXI4-Lite read
  input  wire logic [daisy_diag_pkg::ADDR_W-1:0] araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // Link decoder events
  input  daisy_diag_pkg::port_evt_t       evt_hi,
  input  daisy_diag_pkg::port_evt_t       evt_lo,
  input  daisy_diag_pkg::serial_evt_t     evt_ser,
  // Link control and tagging
  output logic                            dir_sel,
  output logic                            hi_tx_en,
  output logic                            lo_tx_en,
  output logic [1:0]                      fwd_tag,
  // Interrupt
  output logic                            irq
);
  import daisy_diag_pkg::*;

  // Register hit on an aligned word
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [13:0] idx);
    return (a[1:0] == 2'b00) && (a[ADDR_W-1:2] == idx);
  endfunction

  // Control and interrupt registers
  logic [2:0]       ctrl_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;

  // Per-port diagnostic state
  port_evt_t  evt_a     [NPORT];
  logic [7:0] rc_r      [NPORT];
  logic [7:0] rr_r      [NPORT];
  logic [7:0] bit_r     [NPORT];
  logic [7:0] rc_set    [NPORT];
  logic [7:0] rr_set    [NPORT];
  logic [7:0] bit_set   [NPORT];
  logic       tag_now   [NPORT];
  logic       in_frame_r[NPORT];
  logic       pend_sof_r[NPORT];
  logic       pend_byte_r[NPORT];
  logic       tag_r     [NPORT];
  logic [1:0] disc_p;
  logic [1:0] valid_p;
  logic [1:0] fwd_en;

  assign evt_a[PORT_HI] = evt_hi;
  assign evt_a[PORT_LO] = evt_lo;
  assign dir_sel  = ctrl_r[CTRL_DIR];
  assign hi_tx_en = ctrl_r[CTRL_HITX];
  assign lo_tx_en = ctrl_r[CTRL_LOTX];
  // A response moves on through the opposite port's transmitter
  assign fwd_en[PORT_HI] = ctrl_r[CTRL_LOTX];
  assign fwd_en[PORT_LO] = ctrl_r[CTRL_HITX];

  genvar g;
  generate
    for (g = 0; g < NPORT; g++) begin : g_port
      port_evt_t e;
      logic cmd_ok, resp, fe, unexp, crc_drop, txdis, keep;
      logic sof_late, byte_err, sof_any, byte_any, abn_any, crc_tag, abn_rep;
      assign e      = evt_a[g];
      assign resp   = e.frame_is_resp;
      assign fe     = e.frame_end;
      // Commands are legal only in one direction, responses the other
      assign cmd_ok = (dir_sel == CMD_DIR[g]);
      assign unexp  = fe & (resp == cmd_ok);
      assign crc_drop = fe & e.crc_bad & ~unexp;
      // Response with nowhere to go is dropped
      assign txdis  = fe & resp & ~cmd_ok & ~e.crc_bad & ~fwd_en[g];
      assign keep   = fe & ~e.crc_bad & ~unexp;

      // Marker or decode faults past the initialization byte
      assign sof_late = e.byte_stb & ~e.byte_first & e.byte_sof
                        & in_frame_r[g];
      assign byte_err = e.byte_stb & ~e.byte_first & e.byte_bad;
      assign sof_any  = pend_sof_r[g] | sof_late;
      assign byte_any = pend_byte_r[g] | byte_err;
      // Checksum byte itself bad on a response: tag survives the discard
      assign crc_tag  = crc_drop & resp & e.crc_last_bad;
      assign abn_any  = e.abnormal | e.preamble_miss | e.sync_no_data
                        | e.weak_bit | sof_late | byte_err
                        | crc_tag;
      // Byte faults reach the register only for a kept frame
      assign abn_rep  = e.abnormal | e.preamble_miss | e.sync_no_data
                        | e.weak_bit | crc_tag
                        | (keep & (sof_any | byte_any));

      // Checksum-discarded frames set only the checksum flag in rc and rr
      assign rc_set[g] = {4'h0,
                          keep & ~resp & sof_any,
                          keep & ~resp & byte_any,
                          fe & ~resp & ~cmd_ok,
                          crc_drop & ~resp};
      assign rr_set[g] = {2'b00,
                          e.hold_abort & e.hold_bcast,
                          txdis,
                          keep & resp & sof_any,
                          keep & resp & byte_any,
                          fe & resp & cmd_ok,
                          crc_drop & resp};
      assign bit_set[g] = {3'b000, abn_rep, 1'b0,
                           e.sync_no_data,
                           e.preamble_miss,
                           e.weak_bit};
      assign tag_now[g] = abn_any;
      assign disc_p[g]  = crc_drop | txdis;
      assign valid_p[g] = keep & ~txdis;

      // Frame tracking and per-frame pending errors
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          in_frame_r[g]  <= 1'b0;
          pend_sof_r[g]  <= 1'b0;
          pend_byte_r[g] <= 1'b0;
        end else if (fe || (e.byte_stb && e.byte_first)) begin
          in_frame_r[g]  <= ~fe;
          pend_sof_r[g]  <= 1'b0;
          pend_byte_r[g] <= 1'b0;
        end else begin
          pend_sof_r[g]  <= sof_any;
          pend_byte_r[g] <= byte_any;
        end
      end

      // Forward tag: cleared at each new frame, so clean frames go out
      // untagged
      always_ff @(posedge aclk) begin
        if (!aresetn)
          tag_r[g] <= 1'b0;
        else if (tag_now[g])
          tag_r[g] <= 1'b1;
        else if (e.byte_stb && e.byte_first)
          tag_r[g] <= 1'b0;
      end
      assign fwd_tag[g] = tag_r[g];

      // Sticky flags except bit_r bit 3, which follows tag_in at each frame end; no software path writes them
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          rc_r[g]  <= DIAG_RST;
          rr_r[g]  <= DIAG_RST;
          bit_r[g] <= DIAG_RST;
        end else begin
          rc_r[g]     <= rc_r[g] | rc_set[g];
          rr_r[g]     <= rr_r[g] | rr_set[g];
          bit_r[g][7:4] <= bit_r[g][7:4] | bit_set[g][7:4];
          bit_r[g][2:0] <= bit_r[g][2:0] | bit_set[g][2:0];
          if (fe)
            bit_r[g][3] <= e.tag_in;
        end
      end
    end
  endgenerate

  // Counter sources: slot 0 serial port, slot 1 high side
  logic [1:0] c_disc;
  logic [1:0] c_valid;
  logic [1:0] c_rd;
  logic [7:0] disc_r  [2];
  logic [15:0] live_r [2];
  logic [15:0] lat_r  [2];
  logic       ar_fire;

  assign c_disc  = {disc_p[PORT_HI], evt_ser.discard};
  assign c_valid = {valid_p[PORT_HI], evt_ser.valid};
  assign ar_fire = arvalid & arready;
  assign c_rd    = {ar_fire & reg_hit(araddr, IDX_HI_DISC),
                    ar_fire & reg_hit(araddr, IDX_SER_DISC)};

  genvar k;
  generate
    for (k = 0; k < 2; k++) begin : g_cnt
      logic [7:0]  disc_inc;
      logic [15:0] live_inc;
      // Saturate rather than wrap, so a full count stays meaningful
      assign disc_inc = (c_disc[k] && disc_r[k] != CNT_MAX)
                        ? 8'(disc_r[k] + 8'h01) : disc_r[k];
      assign live_inc = (c_valid[k] && live_r[k] != {CNT_MAX, CNT_MAX})
                        ? 16'(live_r[k] + 16'h0001) : live_r[k];

      // A read of the discard register restarts both counts; a same-cycle event is kept
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          disc_r[k] <= DIAG_RST;
          live_r[k] <= {DIAG_RST, DIAG_RST};
          lat_r[k]  <= {DIAG_RST, DIAG_RST};
        end else if (c_rd[k]) begin
          disc_r[k] <= {7'h00, c_disc[k]};
          live_r[k] <= {15'h0000, c_valid[k]};
          lat_r[k]  <= live_r[k];
        end else begin
          disc_r[k] <= disc_inc;
          live_r[k] <= live_inc;
        end
      end
    end
  endgenerate

  // Interrupt events: one bit per diagnostic register, plus discards
  logic [IRQ_W-1:0] irq_evt;
  assign irq_evt = {|c_disc,
                    |bit_set[PORT_LO], |rr_set[PORT_LO], |rc_set[PORT_LO],
                    |bit_set[PORT_HI], |rr_set[PORT_HI], |rc_set[PORT_HI]};
  assign irq = |(irq_stat_r & irq_mask_r);

  // Write channel: address and data taken in either order
  wr_state_t             wst_r;
  wr_state_t             wst_nxt;
  logic [ADDR_W-1:0]     waddr_r;
  logic [31:0]           wdata_r;
  logic [3:0]            wstrb_r;
  logic                  aw_fire;
  logic                  w_fire;
  logic                  wr_go;
  logic [ADDR_W-1:0]     wa;
  logic [31:0]           wd;
  logic [3:0]            ws;
  logic                  wr_ctrl;
  logic                  wr_mask;
  logic                  wr_stat;
  logic                  wr_ro;
  logic [1:0]            bresp_r;

  assign awready = (wst_r == W_IDLE) | (wst_r == W_DATA);
  assign wready  = (wst_r == W_IDLE) | (wst_r == W_ADDR);
  assign aw_fire = awvalid & awready;
  assign w_fire  = wvalid & wready;
  assign wr_go   = (wst_r == W_IDLE & aw_fire & w_fire)
                 | (wst_r == W_ADDR & w_fire)
                 | (wst_r == W_DATA & aw_fire);
  assign wa = (wst_r == W_ADDR) ? waddr_r : awaddr;
  assign wd = (wst_r == W_DATA) ? wdata_r : wdata;
  assign ws = (wst_r == W_DATA) ? wstrb_r : wstrb;

  // Write decode; diagnostic registers accept and ignore writes
  assign wr_ctrl = wr_go & ws[0] & reg_hit(wa, IDX_CTRL);
  assign wr_mask = wr_go & ws[0] & reg_hit(wa, IDX_IRQ_MASK);
  assign wr_stat = wr_go & ws[0] & reg_hit(wa, IDX_IRQ_STAT);
  assign wr_ro   = (wa[1:0] == 2'b00)
                 & (wa[ADDR_W-1:2] >= IDX_HI_BIT)
                 & (wa[ADDR_W-1:2] <= IDX_HI_VLO)
                 & (wa[ADDR_W-1:2] != 14'h078b);

  always_comb begin
    wst_nxt = wst_r;
    case (wst_r)
      W_IDLE: begin
        if (wr_go)
          wst_nxt = W_RESP;
        else if (aw_fire)
          wst_nxt = W_ADDR;
        else if (w_fire)
          wst_nxt = W_DATA;
      end
      W_ADDR: begin
        if (wr_go)
          wst_nxt = W_RESP;
      end
      W_DATA: begin
        if (wr_go)
          wst_nxt = W_RESP;
      end
      W_RESP: begin
        if (bready)
          wst_nxt = W_IDLE;
      end
      default: wst_nxt = W_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_r   <= W_IDLE;
      waddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bresp_r <= RESP_OKAY;
    end else begin
      wst_r <= wst_nxt;
      if (aw_fire)
        waddr_r <= awaddr;
      if (w_fire) begin
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_go)
        bresp_r <= (reg_hit(wa, IDX_CTRL) | reg_hit(wa, IDX_IRQ_MASK)
                    | reg_hit(wa, IDX_IRQ_STAT) | wr_ro)
                   ? RESP_OKAY : RESP_SLVERR;
    end
  end
  assign bvalid = (wst_r == W_RESP);
  assign bresp  = bresp_r;

  // Control, mask and write-one-to-clear status; a new event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= CTRL_RST;
      irq_mask_r <= '0;
      irq_stat_r <= '0;
    end else begin
      if (wr_ctrl)
        ctrl_r <= wd[2:0];
      if (wr_mask)
        irq_mask_r <= wd[IRQ_W-1:0];
      irq_stat_r <= (irq_stat_r & ~(wr_stat ? wd[IRQ_W-1:0] : '0))
                    | irq_evt;
    end
  end

  // Read mux over the map; holes answer with an error
  logic [7:0] rd_byte;
  logic       rd_ok;
  assign rd_byte =
      reg_hit(araddr, IDX_HI_BIT)   ? bit_r[PORT_HI] :
      reg_hit(araddr, IDX_HI_RC)    ? rc_r[PORT_HI] :
      reg_hit(araddr, IDX_HI_RR)    ? rr_r[PORT_HI] :
      reg_hit(araddr, IDX_LO_BIT)   ? bit_r[PORT_LO] :
      reg_hit(araddr, IDX_LO_RC)    ? rc_r[PORT_LO] :
      reg_hit(araddr, IDX_LO_RR)    ? rr_r[PORT_LO] :
      reg_hit(araddr, IDX_SER_DISC) ? disc_r[0] :
      reg_hit(araddr, IDX_HI_DISC)  ? disc_r[1] :
      reg_hit(araddr, IDX_SER_VHI)  ? lat_r[0][15:8] :
      reg_hit(araddr, IDX_SER_VLO)  ? lat_r[0][7:0] :
      reg_hit(araddr, IDX_HI_VHI)   ? lat_r[1][15:8] :
      reg_hit(araddr, IDX_HI_VLO)   ? lat_r[1][7:0] :
      reg_hit(araddr, IDX_IRQ_STAT) ? {1'b0, irq_stat_r} :
      reg_hit(araddr, IDX_IRQ_MASK) ? {1'b0, irq_mask_r} :
      reg_hit(araddr, IDX_CTRL)     ? {5'h00, ctrl_r} : 8'h00;
  assign rd_ok = wr_ro_rd(araddr);

  function automatic logic wr_ro_rd(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'b00)
         & (((a[ADDR_W-1:2] >= IDX_HI_BIT) & (a[ADDR_W-1:2] <= IDX_HI_VLO)
             & (a[ADDR_W-1:2] != 14'h078b))
            | (a[ADDR_W-1:2] >= IDX_IRQ_STAT)
              & (a[ADDR_W-1:2] <= IDX_CTRL));
  endfunction

  // One read in flight; answer one cycle after the address is taken
  logic        rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0]  rresp_r;
  assign arready = ~rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r  <= 32'h00000000;
      rresp_r  <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_r <= 1'b1;
      rdata_r  <= {24'h000000, rd_byte};
      rresp_r  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign rvalid = rvalid_r;
  assign rdata  = rdata_r;
  assign rresp  = rresp_r;

endmodule

// ---- dv/daisy_diag_assertions.sv ----
/*
  Port checker for the daisy-chain diagnostic block.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/1ps
module daisy_diag_assertions
  import daisy_diag_pkg::*;
(
  // Clock and reset
  input wire logic                      aclk,
  input wire logic                      aresetn,
  // Register bus
  input wire logic                      arvalid,
  input wire logic                      arready,
  input wire logic                      rvalid,
  input wire logic                      rready,
  input wire logic [31:0]               rdata,
  input wire logic [1:0]                rresp,
  input wire logic                      bvalid,
  input wire logic                      bready,
  input wire logic [1:0]                bresp,
  // Link side
  input wire daisy_diag_pkg::port_evt_t evt_hi,
  input wire daisy_diag_pkg::port_evt_t evt_lo,
  input wire logic [1:0]                fwd_tag,
  input wire logic                      irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // A clean init byte must drop the tag of the last frame
  wire clean_hi = evt_hi.byte_stb & evt_hi.byte_first & ~evt_hi.byte_sof &
    ~evt_hi.byte_bad & ~evt_hi.abnormal & ~evt_hi.weak_bit &
    ~evt_hi.preamble_miss & ~evt_hi.sync_no_data;

  AST_SOF_TAG: assert property (evt_hi.byte_stb && evt_hi.byte_sof &&
    !evt_hi.byte_first |=> fwd_tag[0]) else $error("late marker untagged");
  AST_BIT_TAG: assert property (evt_lo.weak_bit || evt_lo.sync_no_data ||
    evt_lo.preamble_miss |=> fwd_tag[1]) else $error("bit error untagged");
  AST_ABN_TAG: assert property (evt_hi.abnormal |=> fwd_tag[0])
    else $error("abnormal frame untagged");
  AST_CLEAN_UNTAG: assert property (clean_hi |=> !fwd_tag[0])
    else $error("clean frame tagged");
  AST_TAG_HOLD: assert property (fwd_tag[1] && !evt_lo.byte_first
    |=> fwd_tag[1]) else $error("tag dropped in frame");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  AST_RD_STAND: assert property (rvalid && !rready |=> rvalid &&
    $stable(rdata) && $stable(rresp)) else $error("read data moved");
  AST_RD_BYTE: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_WR_STAND: assert property (bvalid && !bready |=> bvalid &&
    $stable(bresp)) else $error("write response moved");
  AST_RST_QUIET: assert property (disable iff (1'b0) !aresetn |=>
    !rvalid && !bvalid && fwd_tag == 2'b00 && !irq)
    else $error("outputs active after reset");

  // Main scenarios
  AST_COV_ABORT: cover property (evt_hi.hold_abort && evt_hi.hold_bcast);
  AST_COV_SLVERR: cover property (rvalid && rresp == RESP_SLVERR);
  AST_COV_IRQ: cover property (irq);
endmodule
bind daisy_chain_comm_diagnostics daisy_diag_assertions chk_u (
  .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready),
  .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
  .bvalid(bvalid), .bready(bready), .bresp(bresp), .evt_hi(evt_hi),
  .evt_lo(evt_lo), .fwd_tag(fwd_tag), .irq(irq));

// ---- dv/chain_neighbour_model.sv ----
/*
  Neighbour device on one daisy-chain port, seen through the link
  decoder's event pulses. Tasks are called by the bench; one frame
  is init byte, one body byte, then the checksum close.
*/
`timescale 1ns/1ps
module chain_neighbour_model (
  // Clock
  input  wire logic               aclk,
  // Decoded events toward the block
  output daisy_diag_pkg::port_evt_t evt
);
  import daisy_diag_pkg::*;
  initial evt = '0;

  // Qualifiers are cleared between frames so stale ones never leak
  task automatic frame(input logic resp, sof, bad, crc, last, tag);
    port_evt_t e;
    e = '0;
    e.frame_is_resp = resp;
    e.byte_stb = 1'b1;
    e.byte_first = 1'b1;
    @(posedge aclk) evt <= e;
    e.byte_first = 1'b0;
    e.byte_sof = sof;
    e.byte_bad = bad;
    @(posedge aclk) evt <= e;
    e.byte_stb = 1'b0;
    e.byte_sof = 1'b0;
    e.byte_bad = 1'b0;
    e.frame_end = 1'b1;
    e.crc_bad = crc;
    e.crc_last_bad = last;
    e.tag_in = tag;
    @(posedge aclk) evt <= e;
    @(posedge aclk) evt <= '0;
  endtask

  // Single line-level event outside a frame
  task automatic line(input port_evt_t e);
    @(posedge aclk) evt <= e;
    @(posedge aclk) evt <= '0;
  endtask
endmodule

// ---- dv/test_daisy_chain_comm_diagnostics.sv ----
/*
  Self-checking bench for the daisy-chain diagnostic block.
  Assumes the checker is bound and two neighbour models feed the ports.
*/
`timescale 1ns/1ps
module test_daisy_chain_comm_diagnostics;
  import daisy_diag_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic dir_sel, hi_tx_en, lo_tx_en;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, s;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r, fwd_tag;
  logic [13:0] idx;
  port_evt_t   evt_hi, evt_lo, e;
  serial_evt_t evt_ser;
  int seed = 92548;
  int n_mismatch = 0;
  int n_compared = 0;
  int n, k, nv, nd;

  daisy_chain_comm_diagnostics dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .evt_hi(evt_hi), .evt_lo(evt_lo), .evt_ser(evt_ser),
    .dir_sel(dir_sel), .hi_tx_en(hi_tx_en), .lo_tx_en(lo_tx_en),
    .fwd_tag(fwd_tag), .irq(irq));
  chain_neighbour_model nb_hi (.aclk(aclk), .evt(evt_hi));
  chain_neighbour_model nb_lo (.aclk(aclk), .evt(evt_lo));

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  function automatic logic [7:0] sat8(input int c);
    return (c > 255) ? 8'hff : c[7:0];
  endfunction

  task automatic stop_test;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Both channels offered together, each dropped once taken
  task automatic wr(input logic [13:0] i, input logic [31:0] v,
                    output logic [1:0] rs);
    logic ta, tw;
    @(posedge aclk);
    awaddr <= {i, 2'b00};
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    repeat (50) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    stop_test;
  endtask

  task automatic rd(input logic [13:0] i, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ta;
    @(posedge aclk);
    araddr <= {i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    repeat (50) begin
      @(negedge aclk);
      ta = arvalid & arready;
      v = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        return;
      end
    end
    n_mismatch++;
    stop_test;
  endtask

  task automatic rchk(input logic [13:0] i, input logic [7:0] exp);
    rd(i, d, r);
    chk(d, {24'h000000, exp});
  endtask

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = 4'hf;
    evt_ser = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    // Zero after reset, writes ignored, hole refused
    for (idx = IDX_HI_BIT; idx <= IDX_HI_DISC; idx++) begin
      rchk(idx, 8'h00);
      wr(idx, $random(seed), r);
      chk(r, RESP_OKAY);
      rchk(idx, 8'h00);
    end
    rd(14'h078b, d, r);
    chk(r, RESP_SLVERR);
    wr(14'h078b, $random(seed), r);
    chk(r, RESP_SLVERR);
    $display("test read_only done");
    // Wrong-direction frames, then a legal late-marker command, with direction select at 0
    nb_hi.frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rchk(IDX_HI_RC, 8'h02);
    nb_lo.frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rchk(IDX_LO_RR, 8'h02);
    nb_lo.frame(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    rchk(IDX_LO_RC, 8'h08);
    rchk(IDX_LO_BIT, 8'h10);
    $display("test direction_zero done");
    // Direction 1, both transmitters off
    wr(IDX_CTRL, 32'h1, r);
    chk({dir_sel, hi_tx_en, lo_tx_en}, 3'b100);
    // Bad body byte in a checksum-dropped frame stays unreported
    nb_hi.frame(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0);
    rchk(IDX_HI_RC, 8'h03);
    rchk(IDX_HI_BIT, 8'h00);
    e = '0;
    e.abnormal = 1'b1;
    nb_hi.line(e);
    rchk(IDX_HI_BIT, 8'h10);
    nb_hi.frame(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    rchk(IDX_HI_RC, 8'h0f);
    rchk(IDX_HI_BIT, 8'h10);
    nb_lo.frame(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rchk(IDX_LO_RR, 8'h12);
    nb_lo.frame(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0);
    rchk(IDX_LO_RR, 8'h13);
    e = '0;
    e.hold_abort = 1'b1;
    e.hold_bcast = 1'b1;
    nb_hi.line(e);
    rchk(IDX_HI_RR, 8'h20);
    e.hold_bcast = 1'b0;
    nb_lo.line(e);
    rchk(IDX_LO_RR, 8'h13);
    nb_hi.frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    rchk(IDX_HI_BIT, 8'h18);
    nb_hi.frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    rchk(IDX_HI_BIT, 8'h10);
    e = '0;
    e.weak_bit = 1'b1;
    nb_lo.line(e);
    rchk(IDX_LO_BIT, 8'h11);
    e = '0;
    e.preamble_miss = 1'b1;
    nb_lo.line(e);
    rchk(IDX_LO_BIT, 8'h13);
    e = '0;
    e.sync_no_data = 1'b1;
    nb_lo.line(e);
    rchk(IDX_LO_BIT, 8'h17);
    $display("test direction_one done");
    // Interrupt: masked, unmasked, cleared
    @(negedge aclk) chk(irq, 1'b0);
    wr(IDX_IRQ_MASK, 32'h1, r);
    @(negedge aclk) chk(irq, 1'b1);
    wr(IDX_IRQ_STAT, 32'h1, r);
    @(negedge aclk) chk(irq, 1'b0);
    $display("test interrupt done");
    // Counters; the first read restarts both
    rd(IDX_HI_DISC, d, r);
    n = ($random(seed) & 15) + 1;
    k = ($random(seed) & 3) + 1;
    repeat (n) nb_hi.frame(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    repeat (k) nb_hi.frame(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    rchk(IDX_HI_DISC, sat8(k));
    rchk(IDX_HI_VLO, sat8(n));
    rchk(IDX_HI_VHI, 8'h00);
    nv = 0;
    nd = 0;
    // Discard biased high so it runs into saturation
    repeat (400) begin
      @(posedge aclk);
      s = $random(seed);
      evt_ser <= '{discard: s[1] | s[2], valid: s[0]};
      nd += int'(s[1] | s[2]);
      nv += int'(s[0]);
    end
    @(posedge aclk) evt_ser <= '0;
    rchk(IDX_SER_DISC, sat8(nd));
    rchk(IDX_SER_VLO, nv[7:0]);
    rchk(IDX_SER_VHI, nv[15:8]);
    $display("test counters done");
    stop_test;
  end
endmodule
